// ### logic/sfec_erase_ctrl.sv
`default_nettype none
module sfec_erase_ctrl
   import sfec_pkg::*;
#(
   parameter int              CAP_BITS       = CAP_BITS_DEF,
   parameter int              SECTOR_BITS    = SEC_BITS_DEF,
   parameter logic [7:0]      OP_WRITE_EN    = 8'h06,
   parameter logic [7:0]      OP_WRITE_DIS   = 8'h04,
   parameter longint unsigned PAGE_CYCLES    = PAGE_WRITE_CYCLES,
   parameter longint unsigned STATUS_CYCLES  = STATUS_WRITE_CYCLES,
   parameter longint unsigned SECTOR_CYCLES  = SECTOR_ERASE_CYCLES,
   parameter longint unsigned ARRAY_CYCLES   = ARRAY_ERASE_CYCLES
) (
   // clock and reset
   input  wire logic  ref_clk,
   input  wire logic  nrst,
   // serial link pins
   input  wire logic  chip_select_n,
   input  wire logic  serial_clock,
   input  wire logic  serial_data_in,
   // self-timed write requests from same-clock logic
   input  wire logic  page_write_start,
   input  wire logic  status_write_start,
   // status
   output logic       wip,
   output logic       wel,
   output logic       active,
   // command to the array
   output var sfec_erase_t erase_cmd
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation and edges
   sfec_pins_t  pins_raw;
   sfec_pins_t  pins_s;
   logic        sclk_d_reg;
   logic        cs_d_reg;
   logic        sclk_rise;
   logic        cs_rise;

   assign pins_raw = {chip_select_n, serial_clock, serial_data_in};

   sfec_sync #(
      .W       ($bits(sfec_pins_t)),
      .RST_VAL (PINS_RST)
   ) u_sync (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .d       (pins_raw),
      .q       (pins_s)
   );

   // serial clock is only sampled, so it must stay well below ref_clk / 2
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sclk_d_reg <= 1'b0;
         cs_d_reg   <= 1'b1;
      end else begin
         sclk_d_reg <= pins_s.sclk;
         cs_d_reg   <= pins_s.cs_n;
      end
   end

   assign sclk_rise = pins_s.sclk && !sclk_d_reg;
   assign cs_rise   = pins_s.cs_n && !cs_d_reg;

   ////////////////////////////////////////////////////////////////////////////
   // command shifter
   logic [6:0]  shift_reg;
   logic [2:0]  bit_cnt_reg;
   logic [2:0]  byte_cnt_reg;
   logic [7:0]  op_reg;
   logic [23:0] addr_reg;
   logic [7:0]  byte_in;

   assign byte_in = {shift_reg, pins_s.sdi};

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         shift_reg    <= 7'h0;
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= 3'h0;
         op_reg       <= 8'h0;
         addr_reg     <= 24'h0;
      end else if (pins_s.cs_n) begin
         bit_cnt_reg  <= 3'h0;
         byte_cnt_reg <= 3'h0;
      end else if (sclk_rise) begin
         shift_reg   <= byte_in[6:0];
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         if (bit_cnt_reg == 3'h7) begin
            if (byte_cnt_reg == 3'h0) begin
               op_reg <= byte_in;
            end else if (byte_cnt_reg <= 3'(ADDR_BYTES)) begin
               addr_reg <= {addr_reg[15:0], byte_in};
            end
            // saturate so long frames cannot wrap into a valid count
            if (byte_cnt_reg != 3'h7) begin
               byte_cnt_reg <= byte_cnt_reg + 3'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decode at the end of a frame
   sfec_state_t state_reg;
   logic        idle;
   logic        framed;
   logic        array_go;
   logic        sector_go;
   logic        wren_go;
   logic        wrdi_go;
   logic        page_go;
   logic        stat_go;
   logic        start;

   assign idle   = (state_reg == ST_IDLE);
   assign framed = cs_rise && (bit_cnt_reg == 3'h0) && idle;

   assign array_go  = framed && (byte_cnt_reg == 3'h1) && (op_reg == OP_ARRAY_ERASE) && wel;
   assign sector_go = framed && (byte_cnt_reg == 3'h4) && (op_reg == OP_SECTOR_ERASE) && wel;
   assign wren_go   = framed && (byte_cnt_reg == 3'h1) && (op_reg == OP_WRITE_EN);
   assign wrdi_go   = framed && (byte_cnt_reg == 3'h1) && (op_reg == OP_WRITE_DIS);
   // link erase commands win over same-cycle local requests
   assign page_go   = page_write_start && wel && idle && !array_go && !sector_go;
   assign stat_go   = status_write_start && wel && idle && !array_go && !sector_go
                      && !page_write_start;
   assign start     = array_go || sector_go || page_go || stat_go;

   ////////////////////////////////////////////////////////////////////////////
   // self-timed cycle
   logic [TIMER_W-1:0] load_val;
   logic               timer_done;
   logic [23:0]        target_reg;

   always_comb begin
      load_val = TIMER_W'(STATUS_CYCLES);
      if (array_go) begin
         load_val = TIMER_W'(ARRAY_CYCLES);
      end else if (sector_go) begin
         load_val = TIMER_W'(SECTOR_CYCLES);
      end else if (page_go) begin
         load_val = TIMER_W'(PAGE_CYCLES);
      end
   end

   sfec_timer #(
      .W (TIMER_W)
   ) u_timer (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .load    (start),
      .count   (load_val),
      .done    (timer_done)
   );

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
      end else if (array_go) begin
         state_reg <= ST_ARRAY;
      end else if (sector_go) begin
         state_reg <= ST_SECTOR;
      end else if (page_go) begin
         state_reg <= ST_PAGE;
      end else if (stat_go) begin
         state_reg <= ST_STATUS;
      end else if (timer_done) begin
         state_reg <= ST_IDLE;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wip <= 1'b0;
      end else if (start) begin
         wip <= 1'b1;
      end else if (timer_done) begin
         wip <= 1'b0;
      end
   end

   // latch cleared as the cycle starts
   // a fresh enable landing with a local start wins over the clear
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wel <= 1'b0;
      end else if (wren_go) begin
         wel <= 1'b1;
      end else if (start || wrdi_go) begin
         wel <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         target_reg <= 24'h0;
      end else if (sector_go) begin
         target_reg <= sfec_align(addr_reg, CAP_BITS, SECTOR_BITS);
      end
   end

   // array filled with ones when the cycle ends
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         erase_cmd <= '0;
      end else begin
         erase_cmd.valid <= timer_done && (state_reg == ST_ARRAY || state_reg == ST_SECTOR);
         erase_cmd.whole <= (state_reg == ST_ARRAY);
         erase_cmd.base  <= (state_reg == ST_ARRAY) ? 24'h0 : target_reg;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         active <= 1'b0;
      end else begin
         active <= !pins_s.cs_n || !idle || start;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_array_start: assert property (@(posedge ref_clk) disable iff (!nrst)
      array_go |=> state_reg == ST_ARRAY && wip && !wel)
      else $error("array erase did not start");

   a_latch_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(wip) |-> !wel || $past(wren_go))
      else $error("latch still set in cycle");

   a_sector_start: assert property (@(posedge ref_clk) disable iff (!nrst)
      sector_go |=> state_reg == ST_SECTOR ##1 wip)
      else $error("sector erase did not start");

   a_sector_wel: assert property (@(posedge ref_clk) disable iff (!nrst)
      $rose(state_reg == ST_SECTOR) |-> $past(wel))
      else $error("sector erase without latch");

   a_no_wel_ignore: assert property (@(posedge ref_clk) disable iff (!nrst)
      (cs_rise && !wel && idle) |=> state_reg == ST_IDLE)
      else $error("erase ran without latch");

   a_unframed_ignore: assert property (@(posedge ref_clk) disable iff (!nrst)
      (cs_rise && bit_cnt_reg != 3'h0 && idle && !page_write_start && !status_write_start)
      |=> state_reg == ST_IDLE)
      else $error("unframed erase accepted");

   a_wip_state: assert property (@(posedge ref_clk) disable iff (!nrst)
      wip == (state_reg != ST_IDLE))
      else $error("progress flag out of step");

   a_fill_at_end: assert property (@(posedge ref_clk) disable iff (!nrst)
      erase_cmd.valid |-> !wip && $past(wip, 1))
      else $error("erase issued outside cycle end");

   a_sector_align: assert property (@(posedge ref_clk) disable iff (!nrst)
      (erase_cmd.valid && !erase_cmd.whole)
      |-> (erase_cmd.base & ~sfec_align(ADDR_ONES, CAP_BITS, SECTOR_BITS)) == 24'h0)
      else $error("sector base not masked");

   a_page_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
      page_go |=> (state_reg == ST_PAGE && wip) [*2])
      else $error("page write ended early");

   a_status_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
      stat_go |=> (state_reg == ST_STATUS && wip) [*2])
      else $error("status write ended early");

   a_active_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
      (pins_s.cs_n && idle && !start) |=> !active)
      else $error("no standby after idle");

endmodule : sfec_erase_ctrl
`default_nettype wire

// ### shared/sfec_pkg.sv
`default_nettype none
package sfec_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // opcodes, taken most significant bit first
   localparam logic [7:0] OP_ARRAY_ERASE  = 8'hc7;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;

   ////////////////////////////////////////////////////////////////////////////
   // address field layout
   localparam int         ADDR_W       = 24;
   localparam int         ADDR_BYTES   = 3;
   localparam int         CAP_BITS_DEF = 24;
   localparam int         SEC_BITS_DEF = 16;
   localparam logic [23:0] ADDR_ONES   = 24'hffffff;

   ////////////////////////////////////////////////////////////////////////////
   // self-timed cycle lengths
   localparam longint unsigned CLK_HZ                  = 25_000_000;
   localparam longint unsigned PAGE_WRITE_TIME_US      = 1500;
   localparam longint unsigned STATUS_WRITE_TIME_US    = 5000;
   localparam longint unsigned SECTOR_ERASE_TIME_MS    = 2000;
   localparam longint unsigned ARRAY_ERASE_TIME_MS     = 3000;
   localparam longint unsigned PAGE_WRITE_CYCLES   = PAGE_WRITE_TIME_US * CLK_HZ / 1_000_000;
   localparam longint unsigned STATUS_WRITE_CYCLES = STATUS_WRITE_TIME_US * CLK_HZ / 1_000_000;
   localparam longint unsigned SECTOR_ERASE_CYCLES = SECTOR_ERASE_TIME_MS * CLK_HZ / 1000;
   localparam longint unsigned ARRAY_ERASE_CYCLES  = ARRAY_ERASE_TIME_MS * CLK_HZ / 1000;
   localparam int              TIMER_W             = 40;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [2:0] PINS_RST = 3'h4;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [4:0] {
      ST_IDLE   = 5'h01,
      ST_ARRAY  = 5'h02,
      ST_SECTOR = 5'h04,
      ST_PAGE   = 5'h08,
      ST_STATUS = 5'h10
   } sfec_state_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic sdi;
   } sfec_pins_t;

   typedef struct packed {
      logic              valid;
      logic              whole;
      logic [ADDR_W-1:0] base;
   } sfec_erase_t;

   // keep only in-capacity bits above the sector offset
   function automatic logic [23:0] sfec_align(input logic [23:0] a,
                                              input int          cap_bits,
                                              input int          sec_bits);
      sfec_align = a & (ADDR_ONES >> (ADDR_W - cap_bits)) & (ADDR_ONES << sec_bits);
   endfunction : sfec_align

endpackage : sfec_pkg
`default_nettype wire

// ### logic/sfec_sync.sv
`default_nettype none
module sfec_sync #(
   parameter int           W       = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   // raw and synchronised levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // first stage feeds only the second
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= RST_VAL;
         q        <= RST_VAL;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : sfec_sync
`default_nettype wire

// ### logic/sfec_timer.sv
`default_nettype none
module sfec_timer #(
   parameter int W = 40
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   // start and length
   input  wire logic         load,
   input  wire logic [W-1:0] count,
   // one-cycle end pulse
   output logic              done
);
   logic [W-1:0] cnt_reg;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg <= '0;
      end else if (load) begin
         cnt_reg <= count;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - W'(1);
      end
   end

   // a load of zero never ends; counts below one are not allowed
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         done <= 1'b0;
      end else begin
         done <= !load && (cnt_reg == W'(1));
      end
   end
endmodule : sfec_timer
`default_nettype wire

// ### dv/sfec_host.sv
`default_nettype none
module sfec_host (
   // serial link pins toward the device
   output var logic chip_select_n,
   output var logic serial_clock,
   output var logic serial_data_in
);
   timeunit 1ns;
   timeprecision 1ns;

   localparam int HALF = 160;

   initial begin
      chip_select_n  = 1'b1;
      serial_clock   = 1'b0;
      serial_data_in = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // msb first framing
   // link clock 3.125 mhz
   // non-blocking so a change on a ref_clk edge lands after sampling
   task automatic send(input logic [31:0] data, input int nbits);
      int i;
      chip_select_n <= 1'b0;
      #HALF;
      for (i = nbits - 1; i >= 0; i--) begin
         serial_data_in <= data[i];
         #HALF serial_clock <= 1'b1;
         #HALF serial_clock <= 1'b0;
      end
      #HALF chip_select_n <= 1'b1;
      // released line flips so a stale bit never looks valid
      serial_data_in <= ~serial_data_in;
      #(3 * HALF);
   endtask : send

endmodule : sfec_host
`default_nettype wire

// ### dv/tb_sfec_erase_ctrl.sv
`default_nettype none
module tb_sfec_erase_ctrl
   import sfec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // short cycle lengths keep the run brief
   localparam int CAP = 21;
   localparam int SEC = 16;
   localparam int ARR = 30;
   localparam int SCT = 20;
   localparam int PG  = 12;
   localparam int ST  = 16;

   logic        ref_clk;
   logic        nrst;
   logic        chip_select_n;
   logic        serial_clock;
   logic        serial_data_in;
   logic        page_write_start;
   logic        status_write_start;
   logic        wip;
   logic        wel;
   logic        active;
   sfec_erase_t erase_cmd;
   int          miscompares;
   int          checked;

   sfec_erase_ctrl #(
      .CAP_BITS(CAP), .SECTOR_BITS(SEC), .PAGE_CYCLES(PG), .STATUS_CYCLES(ST),
      .SECTOR_CYCLES(SCT), .ARRAY_CYCLES(ARR)
   ) sfec_erase_ctrl_i (
      .ref_clk(ref_clk), .nrst(nrst), .chip_select_n(chip_select_n),
      .serial_clock(serial_clock), .serial_data_in(serial_data_in),
      .page_write_start(page_write_start), .status_write_start(status_write_start),
      .wip(wip), .wel(wel), .active(active), .erase_cmd(erase_cmd)
   );

   sfec_host sfec_host_i (
      .chip_select_n(chip_select_n), .serial_clock(serial_clock),
      .serial_data_in(serial_data_in)
   );

   initial ref_clk = 1'b0;
   always #20 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic close_out();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out

   task automatic wren();
      sfec_host_i.send(32'h06, 8);
      chk("wel set", 32'(wel), 32'h1); // latch set
   endtask : wren

   // measure one self-timed cycle from its rise to its fall
   task automatic run_cycle(input string what, input int len, input logic [1:0] vw,
                            input logic [23:0] base, input logic bchk);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (wip !== 1'b1 && n < 400);
      chk({what, " start"}, 32'(wip), 32'h1);
      chk({what, " wel"}, 32'(wel), 32'h0);
      chk({what, " active"}, 32'(active), 32'h1);
      n = 0;
      while (wip === 1'b1 && n < 1000) begin
         @(negedge ref_clk);
         n++;
      end
      chk({what, " length"}, 32'(n), 32'(len));
      chk({what, " cmd"}, 32'({erase_cmd.valid, erase_cmd.whole}), 32'(vw));
      if (bchk)
         chk({what, " base"}, 32'(erase_cmd.base), 32'(base));
      @(negedge ref_clk);
      chk({what, " standby"}, 32'(active), 32'h0);
   endtask : run_cycle

   // a refused command must never raise write-in-progress
   task automatic expect_idle(input string what);
      logic seen;
      seen = 1'b0;
      repeat (40) begin
         @(negedge ref_clk);
         if (wip !== 1'b0)
            seen = 1'b1;
      end
      chk(what, 32'(seen), 32'h0);
   endtask : expect_idle

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk("reset outputs", 32'({wip, wel, active, erase_cmd}), 32'h0); // at rest
   endtask : t_reset

   task automatic t_array();
      fork
         wren();
         begin
            #1200;
            chk("active in frame", 32'(active), 32'h1); // active selected
         end
      join
      chk("active after wren", 32'(active), 32'h0); // standby idle
      fork
         sfec_host_i.send(32'hc7, 8);
         run_cycle("array", ARR + 1, 2'h3, 24'h0, 1'b1);
      join
   endtask : t_array

   task automatic t_sector();
      logic [23:0] a;
      logic [23:0] exp;
      a   = 24'hff3a5c;
      exp = a & ((24'h1 << CAP) - 24'h1) & ~((24'h1 << SEC) - 24'h1);
      wren();
      fork
         sfec_host_i.send({8'hd8, a}, 32);
         run_cycle("sector", SCT + 1, 2'h2, exp, 1'b1);
      join
   endtask : t_sector

   task automatic t_local();
      @(posedge ref_clk) page_write_start <= 1'b1;
      @(posedge ref_clk) page_write_start <= 1'b0;
      expect_idle("page without wel"); // latch required
      wren();
      @(posedge ref_clk) page_write_start <= 1'b1;
      @(posedge ref_clk) page_write_start <= 1'b0;
      run_cycle("page", PG + 1, 2'h0, 24'h0, 1'b0); // page length
      wren();
      @(posedge ref_clk) status_write_start <= 1'b1;
      @(posedge ref_clk) status_write_start <= 1'b0;
      run_cycle("status", ST + 1, 2'h0, 24'h0, 1'b0); // status length
   endtask : t_local

   task automatic t_refuse();
      sfec_host_i.send(32'hc7, 8);
      expect_idle("array without wel"); // latch required
      wren();
      sfec_host_i.send(32'h63, 7);
      expect_idle("partial byte"); // unframed ignored
      chk("wel kept", 32'(wel), 32'h1); // nothing changed
      sfec_host_i.send({8'h00, 8'hd8, 16'h1234}, 24);
      expect_idle("short sector frame"); // wrong count
      chk("wel after short", 32'(wel), 32'h1); // nothing changed
      sfec_host_i.send(32'h04, 8);
      chk("wel dropped", 32'(wel), 32'h0); // write disable
      sfec_host_i.send(32'hc7, 8);
      expect_idle("array after disable"); // latch required
   endtask : t_refuse

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      miscompares        = 0;
      checked            = 0;
      nrst               = 1'b0;
      page_write_start   = 1'b0;
      status_write_start = 1'b0;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      t_reset();
      t_array();
      t_sector();
      t_local();
      t_refuse();
      close_out();
   end

   // watchdog sized well past the longest expected run
   initial begin
      #500000;
      miscompares++;
      close_out();
   end

endmodule : tb_sfec_erase_ctrl
`default_nettype wire
